// ==== verilog/cca_map.svh ====
// Register indices, field positions, reset values and engine constants of the accelerator
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define CCA_CFG_IDX        16'ha078
`define CCA_DATA0_IDX      16'ha07c
`define CCA_DATA1_IDX      16'ha07d
`define CCA_DATA2_IDX      16'ha07e
`define CCA_DATA3_IDX      16'ha07f

// Configuration field positions
`define CCA_CFG_WIDTH_HI   7
`define CCA_CFG_WIDTH_LO   6
`define CCA_CFG_REVERSE    5
`define CCA_CFG_CARRY_DISCARD    4
`define CCA_CFG_SEED       3
`define CCA_CFG_MODE_HI    2
`define CCA_CFG_MODE_LO    0
`define CCA_CFG_BUSY       0

// Reset values
`define CCA_CFG_RST        8'h00
`define CCA_DATA_RST       32'h0000_0000

// Polynomials, top term implied
`define CCA_POLY16_A       32'h0000_8005
`define CCA_POLY16_B       32'h0000_1021
`define CCA_POLY32         32'h04c1_1db7

// Default seeds
`define CCA_SEED_CSUM      32'h0000_0000
`define CCA_SEED_CRC       32'hffff_ffff

// Entry FIFO depth
`define CCA_FIFO_DEPTH     16

`endif

// ==== verilog/cca_pkg.sv ====
// Types shared by the accelerator design
package cca_pkg;

  typedef enum logic [2:0] {
    MODE_OFF    = 3'b000,
    MODE_CSUM8  = 3'b001,
    MODE_CSUM32 = 3'b010,
    MODE_CRC16A = 3'b011,
    MODE_CRC16B = 3'b100,
    MODE_CRC32  = 3'b101,
    MODE_RSVD   = 3'b110,
    MODE_CLEAR  = 3'b111
  } cca_mode_e;

  typedef enum logic [1:0] {
    WIDTH_8  = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_24 = 2'b10,
    WIDTH_32 = 2'b11
  } cca_width_e;

  typedef enum {
    ST_IDLE,
    ST_RUN
  } cca_state_e;

endpackage : cca_pkg

// ==== verilog/cca_top.sv ====
// Checksum and CRC accelerator with APB register slave and operand FIFO
//
// Functional notes
// - Width field codes 00,01,10,11 select 8, 16, 24, 32 bit operands.
// - Reverse bit mirrors operand within selected width before the engine.
// - Seeds written and results read keep natural bit order always.
// - Checksum adds previous carry unless carry discard bit is set.
// - Seed bit set makes a data entry load the seed, not data.
// - Mode 000 disables engine; 001 is 8-bit, 010 is 32-bit checksum.
// - Mode 011 is CRC-16 poly 8005; mode 100 is CRC-16 poly 1021.
// - Mode 101 is CRC-32 poly 04C11DB7; mode 110 reserved.
// - Writing mode 111 clears state and reloads default seed.
// - Busy flag in config bit 0 reads 1 while a result is pending.
// - Mode field write-only; read bits 2..1 are zero, bit 0 busy.
// - Higher bytes written first; low byte write starts computation.
// - Four data bytes form one 32-bit port, each resetting to zero.
// - Result is read back from the same data registers.
// - Latency is one cycle per operand byte (1, 2, 3 or 4) after a one-cycle FIFO pop.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = `CCA_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             empty;
  logic             full;

  assign empty    = (wrPtr == rdPtr);
  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
    end else if (flush) begin
      wrPtr <= '0;
    end else if (inValid && !full) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr <= '0;
    end else if (flush) begin
      rdPtr <= '0;
    end else if (outReady && !empty) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : cca_fifo

module cca_top #(
  parameter int FIFO_DEPTH = `CCA_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  // Entry: seed flag, width code, operand already mirrored if asked
  localparam int ENTRY_W = 35;

  logic [1:0]          inputWidthSel;
  logic                reverseIn;
  logic                carryDiscard;
  logic                seedEntry;
  cca_pkg::cca_mode_e  engineModeSel;
  logic [31:0]         stage;
  logic [31:0]         acc;
  logic                carry;
  cca_pkg::cca_state_e state;
  logic [1:0]          byteIdx;
  logic [1:0]          lastIdx;
  logic                curSeed;
  logic [31:0]         curOperand;
  logic                busy;

  logic                setup;
  logic                access;
  logic                hitCfg;
  logic                hitData0;
  logic                hitData1;
  logic                hitData2;
  logic                hitData3;
  logic                hitAny;
  logic                lowWrite;
  logic                engineOn;
  logic                clearCmd;
  logic                wrDone;

  logic [31:0]         rawOperand;
  logic [31:0]         mirrorAll;
  logic [31:0]         mirrored;
  logic [31:0]         engineOperandIn;
  logic [ENTRY_W-1:0]  pushEntry;
  logic                pushValid;
  logic                pushReady;
  logic [ENTRY_W-1:0]  popEntry;
  logic                popValid;
  logic                popReady;

  logic [31:0]         defaultSeed;
  logic [31:0]         widthMask;
  logic [31:0]         resultMask;
  logic [7:0]          curByte;
  logic [31:0]         next_acc;
  logic                next_carry;
  logic [31:0]         readMux;

  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d,
                                           input logic wide, input logic [31:0] poly);
    logic [31:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    // Operand bits enter least significant first
    for (int i = 0; i < 8; i++) begin
      fb = (wide ? c[31] : c[15]) ^ d[i];
      c  = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ poly;
      end
    end
    if (!wide) begin
      c[31:16] = 16'h0000;
    end
    return c;
  endfunction : crc_byte

  // APB decode; word index compared against full address
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hitCfg   = (paddr == {14'h0000, `CCA_CFG_IDX, 2'b00});
  assign hitData0 = (paddr == {14'h0000, `CCA_DATA0_IDX, 2'b00});
  assign hitData1 = (paddr == {14'h0000, `CCA_DATA1_IDX, 2'b00});
  assign hitData2 = (paddr == {14'h0000, `CCA_DATA2_IDX, 2'b00});
  assign hitData3 = (paddr == {14'h0000, `CCA_DATA3_IDX, 2'b00});
  assign hitAny   = hitCfg || hitData0 || hitData1 || hitData2 || hitData3;

  // Disabled and reserved modes accept no entries, modelling the gated engine
  assign engineOn = (engineModeSel != cca_pkg::MODE_OFF)
                 && (engineModeSel != cca_pkg::MODE_RSVD);
  assign lowWrite = access && pwrite && hitData0;

  // Back-pressure: a full FIFO holds the low-byte write in its access phase
  assign pready   = !(lowWrite && engineOn && !pushReady);
  assign wrDone   = access && pwrite && pready;
  assign clearCmd = wrDone && hitCfg
                 && (pwdata[`CCA_CFG_MODE_HI:`CCA_CFG_MODE_LO] == 3'b111);

  // Operand build, masked to the selected width
  always_comb begin
    case (cca_pkg::cca_width_e'(inputWidthSel))
      cca_pkg::WIDTH_8:  widthMask = 32'h0000_00ff;
      cca_pkg::WIDTH_16: widthMask = 32'h0000_ffff;
      cca_pkg::WIDTH_24: widthMask = 32'h00ff_ffff;
      default:           widthMask = 32'hffff_ffff;
    endcase
  end

  assign rawOperand = {stage[31:8], pwdata[7:0]} & widthMask;

  generate
    for (genvar b = 0; b < 32; b++) begin : g_mirror
      assign mirrorAll[b] = rawOperand[31-b];
    end
  endgenerate

  // Mirror of 32 bits shifted down keeps the reversal within the width
  always_comb begin
    case (cca_pkg::cca_width_e'(inputWidthSel))
      cca_pkg::WIDTH_8:  mirrored = {24'h000000, mirrorAll[31:24]};
      cca_pkg::WIDTH_16: mirrored = {16'h0000, mirrorAll[31:16]};
      cca_pkg::WIDTH_24: mirrored = {8'h00, mirrorAll[31:8]};
      default:           mirrored = mirrorAll;
    endcase
  end

  // Seeds bypass the mirror so their bit order stays natural
  assign engineOperandIn = (reverseIn && !seedEntry) ? mirrored : rawOperand;
  assign pushEntry = {seedEntry, inputWidthSel, engineOperandIn};
  assign pushValid = lowWrite && engineOn;

  cca_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .flush    (clearCmd),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushEntry),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popEntry)
  );

  // Configuration register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inputWidthSel <= 2'(`CCA_CFG_RST >> `CCA_CFG_WIDTH_LO);
      reverseIn     <= 1'b0;
      carryDiscard  <= 1'b0;
      seedEntry     <= 1'b0;
    end else if (wrDone && hitCfg) begin
      inputWidthSel <= pwdata[`CCA_CFG_WIDTH_HI:`CCA_CFG_WIDTH_LO];
      reverseIn     <= pwdata[`CCA_CFG_REVERSE];
      carryDiscard  <= pwdata[`CCA_CFG_CARRY_DISCARD];
      seedEntry     <= pwdata[`CCA_CFG_SEED];
    end
  end

  // Clear code is a command; the stored mode keeps its last real value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      engineModeSel <= cca_pkg::MODE_OFF;
    end else if (wrDone && hitCfg && !clearCmd) begin
      engineModeSel <= cca_pkg::cca_mode_e'(pwdata[`CCA_CFG_MODE_HI:`CCA_CFG_MODE_LO]);
    end
  end

  // Staging bytes for the operand; low byte goes straight into the entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= `CCA_DATA_RST;
    end else if (wrDone) begin
      if (hitData0) begin
        stage[7:0] <= pwdata[7:0];
      end
      if (hitData1) begin
        stage[15:8] <= pwdata[7:0];
      end
      if (hitData2) begin
        stage[23:16] <= pwdata[7:0];
      end
      if (hitData3) begin
        stage[31:24] <= pwdata[7:0];
      end
    end
  end

  // Result size follows the mode
  always_comb begin
    case (engineModeSel)
      cca_pkg::MODE_CSUM8:  resultMask = 32'h0000_00ff;
      cca_pkg::MODE_CRC16A: resultMask = 32'h0000_ffff;
      cca_pkg::MODE_CRC16B: resultMask = 32'h0000_ffff;
      default:              resultMask = 32'hffff_ffff;
    endcase
  end

  always_comb begin
    case (engineModeSel)
      cca_pkg::MODE_CRC16A: defaultSeed = `CCA_SEED_CRC & resultMask;
      cca_pkg::MODE_CRC16B: defaultSeed = `CCA_SEED_CRC & resultMask;
      cca_pkg::MODE_CRC32:  defaultSeed = `CCA_SEED_CRC;
      default:              defaultSeed = `CCA_SEED_CSUM;
    endcase
  end

  // Engine sequencing: one operand byte per cycle
  assign popReady = (state == cca_pkg::ST_IDLE);
  assign curByte  = curOperand[8*byteIdx +: 8];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= cca_pkg::ST_IDLE;
      byteIdx    <= 2'd0;
      lastIdx    <= 2'd0;
      curSeed    <= 1'b0;
      curOperand <= 32'h0000_0000;
    end else if (clearCmd) begin
      state   <= cca_pkg::ST_IDLE;
      byteIdx <= 2'd0;
    end else begin
      case (state)
        cca_pkg::ST_IDLE: begin
          if (popValid) begin
            curSeed    <= popEntry[34];
            lastIdx    <= popEntry[33:32];
            curOperand <= popEntry[31:0];
            byteIdx    <= 2'd0;
            // Seed entries finish in the pop cycle
            if (!popEntry[34]) begin
              state <= cca_pkg::ST_RUN;
            end
          end
        end
        cca_pkg::ST_RUN: begin
          if (byteIdx == lastIdx) begin
            state <= cca_pkg::ST_IDLE;
          end else begin
            byteIdx <= byteIdx + 2'd1;
          end
        end
        default: begin
          state <= cca_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // One byte step of the selected algorithm
  always_comb begin
    logic [8:0]  sum8;
    logic [32:0] sum32;
    logic        cin;
    sum8       = 9'h000;
    sum32      = 33'h0_0000_0000;
    cin        = carryDiscard ? 1'b0 : carry;
    next_acc   = acc;
    next_carry = carry;
    case (engineModeSel)
      cca_pkg::MODE_CSUM8: begin
        sum8       = {1'b0, acc[7:0]} + {1'b0, curByte} + {8'h00, cin};
        next_acc   = {24'h000000, sum8[7:0]};
        next_carry = sum8[8];
      end
      cca_pkg::MODE_CSUM32: begin
        sum32      = {1'b0, acc} + ({25'h0000000, curByte} << (8 * byteIdx))
                   + {32'h0000_0000, cin};
        next_acc   = sum32[31:0];
        next_carry = sum32[32];
      end
      cca_pkg::MODE_CRC16A: next_acc = crc_byte(acc, curByte, 1'b0, `CCA_POLY16_A);
      cca_pkg::MODE_CRC16B: next_acc = crc_byte(acc, curByte, 1'b0, `CCA_POLY16_B);
      cca_pkg::MODE_CRC32:  next_acc = crc_byte(acc, curByte, 1'b1, `CCA_POLY32);
      default: begin
        next_acc   = acc;
        next_carry = carry;
      end
    endcase
  end

  // Accumulator and kept carry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc   <= `CCA_DATA_RST;
      carry <= 1'b0;
    end else if (clearCmd) begin
      acc   <= defaultSeed;
      carry <= 1'b0;
    end else if (state == cca_pkg::ST_IDLE && popValid && popEntry[34]) begin
      acc   <= popEntry[31:0] & resultMask;
      carry <= 1'b0;
    end else if (state == cca_pkg::ST_RUN) begin
      acc   <= next_acc;
      carry <= next_carry;
    end
  end

  // Pending entries count as busy too, so a read never sees a stale result silently
  assign busy = popValid || (state == cca_pkg::ST_RUN);

  // Read path: results come back in natural order
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitCfg) begin
      readMux[7:0] = {inputWidthSel, reverseIn, carryDiscard, seedEntry, 2'b00, busy};
    end else if (hitData0) begin
      readMux[7:0] = acc[7:0];
    end else if (hitData1) begin
      readMux[7:0] = acc[15:8];
    end else if (hitData2) begin
      readMux[7:0] = acc[23:16];
    end else if (hitData3) begin
      readMux[7:0] = acc[31:24];
    end
  end

  // Answer data is captured in the setup cycle and held through the access phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : readMux;
      pslverr <= !hitAny;
    end
  end

endmodule : cca_top

// ==== tb/cca_checker.sv ====
// Bus timing and register checks for the accelerator
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_checker (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  localparam logic [31:0] ACFG = 32'(`CCA_CFG_IDX) << 2;
  localparam logic [31:0] AD0  = 32'(`CCA_DATA0_IDX) << 2;
  logic [4:0] cfgHi;
  logic [2:0] mode;
  logic [6:0] idle;
  logic       done;
  logic       isCfg;
  logic       mapped;
  assign done   = psel && penable && pready;
  assign isCfg  = paddr == ACFG;
  assign mapped = isCfg || (paddr >= AD0 && paddr <= AD0 + 32'hc && paddr[1:0] == 2'b00);
  // Clear code updates the upper fields but leaves the stored mode alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgHi <= 5'h00;
      mode  <= 3'h0;
    end else if (done && pwrite && isCfg) begin
      cfgHi <= pwdata[7:3];
      if (pwdata[2:0] != 3'h7) begin
        mode <= pwdata[2:0];
      end
    end
  end
  // Cycles since the last operand entry; saturates
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle <= 7'h00;
    end else if (done && pwrite && paddr == AD0) begin
      idle <= 7'h00;
    end else if (idle != 7'h7f) begin
      idle <= idle + 7'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_stall_cause: assert property (!pready |-> psel && penable && pwrite && paddr == AD0)
    else $error("wait state outside an operand entry");
  a_stall_bound: assert property ($fell(pready) |-> ##[1:6] pready)
    else $error("wait state too long");
  a_err_map: assert property (psel && !penable |=> pslverr == !$past(mapped))
    else $error("error response does not match the map");
  a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_cfg_read: assert property (psel && penable && !pwrite && isCfg |-> prdata[7:1] == {cfgHi, 2'b00})
    else $error("config readback wrong");
  a_busy_set: assert property (done && pwrite && paddr == AD0 && mode inside {[3'h1:3'h5]} && !cfgHi[0] ##2
    psel && !penable && !pwrite && isCfg |=> prdata[0])
    else $error("busy not shown after entry");
  a_busy_clear: assert property (psel && !penable && !pwrite && isCfg && idle >= 7'd100 |=> !prdata[0])
    else $error("busy stuck");
  a_wait_hold: assert property (psel && penable && !pready |=> $stable(prdata) && $stable(pslverr))
    else $error("response moved during wait");
  c_entry: cover property (done && pwrite && paddr == AD0);
  c_stall: cover property (!pready);
  c_err: cover property (done && pslverr);
endmodule : cca_checker
bind cca_top cca_checker i_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== tb/cca_cpu_model.sv ====
// Processor core model: bus master for the accelerator registers
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_cpu_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  localparam logic [31:0] ACFG = 32'(`CCA_CFG_IDX) << 2;
  int stalls = 0;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
  end
  function automatic logic [31:0] adr(input int i);
    return 32'(`CCA_DATA0_IDX + i) << 2;
  endfunction : adr
  // No wait limit here; the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      stalls++;
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus must not look like the old value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
  task automatic write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : write
  task automatic read(input logic [31:0] a, output logic [31:0] r, output logic e);
    xfer(1'b0, a, 32'h0, r, e);
  endtask : read
  task automatic cfg_wr(input logic [7:0] c);
    write(ACFG, {24'h0, c});
  endtask : cfg_wr
  task automatic cfg_rd(output logic [31:0] r);
    logic e;
    read(ACFG, r, e);
  endtask : cfg_rd
  task automatic set_mode(input logic [7:0] c);
    cfg_wr(c);
    cfg_wr({c[7:3], 3'b111});
  endtask : set_mode
  task automatic submit(input int w, input logic [31:0] v);
    for (int b = w; b >= 0; b--) write(adr(b), {24'h0, v[8*b +: 8]});
  endtask : submit
  task automatic result(output logic [31:0] r);
    logic e;
    for (int b = 0; b < 4; b++) begin
      logic [31:0] t;
      read(adr(b), t, e);
      r[8*b +: 8] = t[7:0];
    end
  endtask : result
endmodule : cca_cpu_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the checksum and CRC accelerator
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] got;
  logic        e;
  int          err_total = 0;
  int          comparisons = 0;
  logic [1:0]  wd[4] = '{2'd0, 2'd1, 2'd3, 2'd2};
  logic        rv[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [2:0]  md[4] = '{3'd3, 3'd4, 3'd5, 3'd5};
  logic [31:0] dv[4] = '{32'h5a, 32'h1234, 32'h1234_5678, 32'hab_cdef};
  always #10 clk = ~clk;
  cca_top i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cca_cpu_model i_cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Bit-serial reference: bit 0 first, no final xor
  function automatic logic [31:0] crc(logic [31:0] acc, logic [31:0] d, int n, logic rev, logic [2:0] m);
    logic [31:0] x;
    logic        fb;
    x = d;
    if (rev) for (int i = 0; i < n; i++) x[i] = d[n-1-i];
    for (int i = 0; i < n; i++) begin
      fb  = acc[m == 3'd5 ? 31 : 15] ^ x[i];
      acc = acc << 1;
      if (fb) acc = acc ^ (m == 3'd3 ? `CCA_POLY16_A : m == 3'd4 ? `CCA_POLY16_B : `CCA_POLY32);
    end
    return m == 3'd5 ? acc : {16'h0, acc[15:0]};
  endfunction : crc
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    i_cpu.cfg_rd(got);
    chk(got, 32'h0);
    i_cpu.result(got);
    chk(got, 32'h0);
    i_cpu.read(32'h100, got, e);
    chk({got[30:0], e}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      i_cpu.set_mode({wd[k], rv[k], 2'b00, md[k]});
      i_cpu.submit(wd[k], dv[k]);
      repeat (8) @(posedge clk);
      i_cpu.result(got);
      chk(got, crc(32'hffff_ffff, dv[k], 8 * (wd[k] + 1), rv[k], md[k]));
    end
    // Seed entry with reverse set must keep natural order
    i_cpu.set_mode(8'h6b);
    i_cpu.submit(1, 32'h1d0f);
    repeat (8) @(posedge clk);
    i_cpu.result(got);
    chk(got, 32'h1d0f);
    i_cpu.cfg_wr(8'h03);
    i_cpu.submit(0, 32'h31);
    repeat (8) @(posedge clk);
    i_cpu.result(got);
    chk(got, crc(32'h1d0f, 32'h31, 8, 1'b0, 3'd3));
    for (int nc = 0; nc < 2; nc++) begin
      i_cpu.set_mode(8'h09);
      i_cpu.submit(0, 32'hf0);
      i_cpu.cfg_wr({3'b000, nc[0], 4'b0001});
      i_cpu.submit(0, 32'h20);
      i_cpu.submit(0, 32'h01);
      repeat (8) @(posedge clk);
      i_cpu.result(got);
      chk(got, 32'h12 - 32'(nc));
    end
    i_cpu.set_mode(8'h02);
    i_cpu.submit(0, 32'hff);
    i_cpu.submit(0, 32'h02);
    // Disabled and reserved codes must leave the sum alone
    for (int m = 0; m < 7; m += 6) begin
      i_cpu.cfg_wr(8'(m));
      i_cpu.submit(0, 32'h07);
    end
    repeat (8) @(posedge clk);
    i_cpu.result(got);
    chk(got, 32'h101);
    // Reset with the engine idle must return every register to its reset value
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    i_cpu.cfg_rd(got);
    chk(got, 32'h0);
    i_cpu.result(got);
    chk(got, 32'h0);
    i_cpu.set_mode(8'hc5);
    i_cpu.submit(3, 32'hdead_beef);
    i_cpu.cfg_rd(got);
    chk(got, 32'hc1);
    repeat (8) @(posedge clk);
    i_cpu.cfg_rd(got);
    chk(got, 32'hc0);
    i_cpu.result(got);
    chk(got, crc(32'hffff_ffff, 32'hdead_beef, 32, 1'b0, 3'd5));
    // Entries faster than the engine drains them fill the queue
    for (int n = 0; n < 60; n++) i_cpu.write(i_cpu.adr(0), 32'(n));
    chk(32'(i_cpu.stalls > 0), 32'h1);
    repeat (120) @(posedge clk);
    i_cpu.cfg_rd(got);
    chk(got, 32'hc0);
    give_verdict();
  end
endmodule : tb_top
